// file: verilog/ajs_pkg.sv
/*
 * Constants, register map and state types for the axis jog/speed block.
 * Assumes a single pclk domain and an APB master on the register side.
 */
package ajs_pkg;
  localparam int NAX  = 2;
  localparam int SPW  = 16;
  localparam int DW   = 32;
  localparam int IW   = 5;
  localparam int NCFG = 14;

  // Word index within an axis block; byte address = {axis, index, 2'b00}
  localparam logic [IW-1:0] R_CTRL    = 5'h00;
  localparam logic [IW-1:0] R_CMD     = 5'h01;
  localparam logic [IW-1:0] R_CMD_SPD = 5'h02;
  localparam logic [IW-1:0] R_BIAS    = 5'h03;
  localparam logic [IW-1:0] R_LIMIT   = 5'h04;
  localparam logic [IW-1:0] R_JOG_SPD = 5'h05;
  localparam logic [IW-1:0] R_ACC     = 5'h06;
  localparam logic [IW-1:0] R_DEC     = 5'h07;
  localparam logic [IW-1:0] R_JOG_ACC = 5'h08;
  localparam logic [IW-1:0] R_JOG_DEC = 5'h09;
  localparam logic [IW-1:0] R_UPPER   = 5'h0a;
  localparam logic [IW-1:0] R_LOWER   = 5'h0b;
  localparam logic [IW-1:0] R_MOVE    = 5'h0c;
  localparam logic [IW-1:0] R_NEWVAL  = 5'h0d;
  localparam logic [IW-1:0] R_STATUS  = 5'h0e;
  localparam logic [IW-1:0] R_FEED    = 5'h0f;
  localparam logic [IW-1:0] R_CODES   = 5'h10;
  localparam logic [IW-1:0] R_LAUNCH  = 5'h11;

  // Control levels, command pulses, status fields
  localparam int C_JOG = 0;
  localparam int C_HALT = 1;
  localparam int C_DIR = 2;
  localparam int K_FEED = 0;
  localparam int K_SPD = 1;
  localparam int K_CHG = 2;
  localparam int K_ERST = 3;
  localparam int L_GO = 0;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_ZERO = 2;
  localparam int S_PH = 4;
  localparam int S_OP = 8;
  localparam int W_LSB = 16;

  // Error, warning and operation state codes
  localparam logic [15:0] E_HALT_AT_START = 16'h044e;
  localparam logic [15:0] E_SOFT_UP       = 16'h044f;
  localparam logic [15:0] E_SOFT_LO       = 16'h0450;
  localparam logic [15:0] W_SPD_RANGE     = 16'h03fc;
  localparam logic [7:0]  OP_IDLE         = 8'h00;
  localparam logic [7:0]  OP_POS          = 8'h01;
  localparam logic [7:0]  OP_JOG          = 8'h02;
  localparam logic [7:0]  OP_SPEED        = 8'h0a;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001, PH_ACC = 4'b0010, PH_RUN = 4'b0100, PH_DEC = 4'b1000
  } ajs_phase_t;
  typedef enum logic [3:0] {
    MD_IDLE = 4'b0001, MD_SPD = 4'b0010, MD_JOG = 4'b0100, MD_POS = 4'b1000
  } ajs_mode_t;

  typedef struct packed {
    ajs_phase_t       ph;
    ajs_mode_t        md;
    logic [SPW-1:0]   speed;
    logic [SPW-1:0]   tgt;
    logic [SPW-1:0]   accu;
    logic [DW-1:0]    feed;
    logic [DW-1:0]    remain;
    logic             busy;
    logic             zero;
    logic             done;
    logic             pulse;
    logic             dir;
    logic             jog_prev;
    logic [15:0]      err;
    logic [15:0]      warn;
  } ajs_axis_t;

  localparam ajs_axis_t AX_RST = '{ph: PH_IDLE, md: MD_IDLE, default: '0};
endpackage : ajs_pkg

// file: verilog/ajs_axis_ctrl.sv
/*
 * Two-axis pulse motion sequencer: current value change, speed control,
 * dual-axis launch and jog, reached over an APB slave.
 * Assumes a synchronous APB master on pclk; pulses feed a drive unit.
 */
module ajs_axis_ctrl
  import ajs_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [DW-1:0]  pwdata,
  output logic      [DW-1:0]  prdata,
  output logic                pready,
  output logic                pslverr,
  // Drive unit pulse outputs
  output logic      [NAX-1:0] pulse_out,
  output logic      [NAX-1:0] dir_out
);

  typedef struct packed {
    logic [NAX-1:0][NCFG-1:0][DW-1:0] cfg;
    ajs_axis_t [NAX-1:0]              ax;
    logic [DW-1:0]                    rdata;
    logic                             rdy;
    logic                             serr;
  } ajs_state_t;

  ajs_state_t state;
  ajs_state_t next_state;

  // Clamp to limit and bias; a limit of zero means no limit
  function automatic logic [SPW:0] clamp_spd(
    input logic [SPW-1:0] v,
    input logic [SPW-1:0] bias,
    input logic [SPW-1:0] lim
  );
    logic [SPW:0] r;
    r = {1'b0, v};
    if (lim != '0 && v > lim)
    begin
      r = {1'b1, lim};
    end
    else if (v < bias)
    begin
      r = {1'b1, bias};
    end
    return r;
  endfunction : clamp_spd

  // Move speed one step toward a target
  function automatic logic [SPW-1:0] ramp(
    input logic [SPW-1:0] cur,
    input logic [SPW-1:0] tgt,
    input logic [SPW-1:0] up,
    input logic [SPW-1:0] dn
  );
    logic [SPW:0] t;
    t = '0;
    if (cur < tgt)
    begin
      t = {1'b0, cur} + {1'b0, up};
      ramp = (t > {1'b0, tgt}) ? tgt : t[SPW-1:0];
    end
    else
    begin
      ramp = (cur - tgt > dn) ? cur - dn : tgt;
    end
  endfunction : ramp

  // Operation state reported for a mode
  function automatic logic [7:0] op_code(input ajs_mode_t md);
    unique case (md)
      MD_SPD:  op_code = OP_SPEED;
      MD_JOG:  op_code = OP_JOG;
      MD_POS:  op_code = OP_POS;
      MD_IDLE: op_code = OP_IDLE;
      default: op_code = OP_IDLE;
    endcase
  endfunction : op_code

  // Decoded APB access
  logic                 sel_ax;
  logic [IW-1:0]        idx;
  logic                 wr_go;
  logic                 setup;
  assign sel_ax = paddr[7];
  assign idx    = paddr[6:2];
  assign setup  = psel & ~penable;
  assign wr_go  = psel & penable & state.rdy & pwrite;

  // Next state: bus, commands and per-axis sequencing
  always_comb
  begin
    logic [NAX-1:0][3:0] cmd;
    logic                launch;
    logic                any_busy;
    logic [SPW:0]        cl;
    logic [SPW-1:0]      bias;
    logic [SPW-1:0]      lim;
    logic [SPW-1:0]      up;
    logic [SPW-1:0]      dn;
    logic [DW-1:0]       move;
    logic [DW-1:0]       nv;
    logic [DW-1:0]       dest;
    logic [SPW:0]        sum;
    logic                jog;
    logic                halt;
    logic                stat_ok;
    cmd        = '0;
    launch     = 1'b0;
    cl         = '0;
    bias       = '0;
    lim        = '0;
    up         = '0;
    dn         = '0;
    move       = '0;
    nv         = '0;
    dest       = '0;
    sum        = '0;
    jog        = 1'b0;
    halt       = 1'b0;
    stat_ok    = 1'b0;
    next_state = state;
    any_busy   = state.ax[0].busy | state.ax[1].busy;

    // Register writes; command words only pulse
    if (wr_go)
    begin
      if (idx == R_CMD)
      begin
        cmd[sel_ax] = pwdata[3:0];
      end
      else if (idx == R_LAUNCH)
      begin
        launch = pwdata[L_GO];
      end
      else if (idx < R_STATUS)
      begin
        next_state.cfg[sel_ax][idx] = pwdata;
      end
    end

    // Registered answer: ready in the access cycle, zero wait states
    next_state.rdy   = setup;
    next_state.serr  = setup & (idx > R_LAUNCH);
    next_state.rdata = '0;
    if (setup && !pwrite)
    begin
      stat_ok = 1'b1;
      if (idx < R_STATUS && idx != R_CMD)
      begin
        next_state.rdata = state.cfg[sel_ax][idx];
      end
      else if (idx == R_STATUS)
      begin
        next_state.rdata[S_BUSY]       = state.ax[sel_ax].busy;
        next_state.rdata[S_DONE]       = state.ax[sel_ax].done;
        next_state.rdata[S_ZERO]       = state.ax[sel_ax].zero;
        next_state.rdata[S_PH +: 4]    = state.ax[sel_ax].ph;
        next_state.rdata[S_OP +: 8]    = op_code(state.ax[sel_ax].md);
      end
      else if (idx == R_FEED)
      begin
        next_state.rdata = state.ax[sel_ax].feed;
      end
      else if (idx == R_CODES)
      begin
        next_state.rdata[15:0]         = state.ax[sel_ax].err;
        next_state.rdata[W_LSB +: 16]  = state.ax[sel_ax].warn;
      end
    end

    for (int a = 0; a < NAX; a++)
    begin
      bias = state.cfg[a][R_BIAS][SPW-1:0];
      lim  = state.cfg[a][R_LIMIT][SPW-1:0];
      nv   = state.cfg[a][R_NEWVAL];
      move = state.cfg[a][R_MOVE];
      jog  = state.cfg[a][R_CTRL][C_JOG];
      halt = state.cfg[a][R_CTRL][C_HALT];
      next_state.ax[a].pulse    = 1'b0;
      next_state.ax[a].jog_prev = jog;

      // Error reset first so a same-cycle event still lands
      if (cmd[a][K_ERST])
      begin
        next_state.ax[a].err  = '0;
        next_state.ax[a].warn = '0;
      end

      // Current value change on a stationary axis
      if (cmd[a][K_FEED] && !state.ax[a].busy)
      begin
        if ($signed(nv) > $signed(state.cfg[a][R_UPPER]))
        begin
          next_state.ax[a].err = E_SOFT_UP;
        end
        else if ($signed(nv) < $signed(state.cfg[a][R_LOWER]))
        begin
          next_state.ax[a].err = E_SOFT_LO;
        end
        else
        begin
          next_state.ax[a].feed = nv;
        end
      end

      // Speed control start
      if (cmd[a][K_SPD] && !state.ax[a].busy)
      begin
        cl = clamp_spd(state.cfg[a][R_CMD_SPD][SPW-1:0], bias, lim);
        next_state.ax[a].md   = MD_SPD;
        next_state.ax[a].busy = 1'b1;
        next_state.ax[a].done = 1'b0;
        next_state.ax[a].feed = '0;
        next_state.ax[a].dir  = state.cfg[a][R_CTRL][C_DIR];
        next_state.ax[a].tgt  = cl[SPW-1:0];
        next_state.ax[a].zero = (cl[SPW-1:0] == '0);
        next_state.ax[a].ph   = PH_ACC;
        if (cl[SPW])
        begin
          next_state.ax[a].warn = W_SPD_RANGE;
        end
      end

      // Jog start on a fresh rising edge only, never while busy
      if (jog && !state.ax[a].jog_prev && !state.ax[a].busy)
      begin
        if (halt)
        begin
          next_state.ax[a].err = E_HALT_AT_START;
        end
        else
        begin
          cl = clamp_spd(state.cfg[a][R_JOG_SPD][SPW-1:0], bias, lim);
          next_state.ax[a].md   = MD_JOG;
          next_state.ax[a].busy = 1'b1;
          next_state.ax[a].done = 1'b0;
          next_state.ax[a].dir  = state.cfg[a][R_CTRL][C_DIR];
          next_state.ax[a].tgt  = cl[SPW-1:0];
          next_state.ax[a].zero = (cl[SPW-1:0] == '0);
          next_state.ax[a].ph   = PH_ACC;
          if (cl[SPW])
          begin
            next_state.ax[a].warn = W_SPD_RANGE;
          end
        end
      end

      // Speed change while running; refused during deceleration and in positioning
      if (cmd[a][K_CHG] && state.ax[a].busy && state.ax[a].ph != PH_DEC
          && state.ax[a].md != MD_POS)
      begin
        cl = clamp_spd(nv[SPW-1:0], bias, lim);
        next_state.ax[a].tgt  = cl[SPW-1:0];
        next_state.ax[a].zero = (cl[SPW-1:0] == '0);
        if (cl[SPW])
        begin
          next_state.ax[a].warn = W_SPD_RANGE;
        end
      end

      // Halt, or jog release, starts the deceleration
      if (state.ax[a].busy && state.ax[a].ph != PH_DEC
          && (halt || (state.ax[a].md == MD_JOG && !jog)))
      begin
        next_state.ax[a].ph = PH_DEC;
      end

      // Ramp rates: jog uses its own parameter block
      up = (state.ax[a].md == MD_JOG) ? state.cfg[a][R_JOG_ACC][SPW-1:0]
                                      : state.cfg[a][R_ACC][SPW-1:0];
      dn = (state.ax[a].md == MD_JOG) ? state.cfg[a][R_JOG_DEC][SPW-1:0]
                                      : state.cfg[a][R_DEC][SPW-1:0];

      // Speed profile
      unique case (state.ax[a].ph)
        PH_ACC, PH_RUN:
        begin
          if (next_state.ax[a].ph != PH_DEC)
          begin
            next_state.ax[a].speed = ramp(state.ax[a].speed, state.ax[a].tgt, up, dn);
            if (state.ax[a].speed == state.ax[a].tgt)
            begin
              next_state.ax[a].ph = PH_RUN;
            end
          end
        end
        PH_DEC:
        begin
          next_state.ax[a].speed = ramp(state.ax[a].speed, '0, up, dn);
          if (state.ax[a].speed == '0)
          begin
            next_state.ax[a].ph   = PH_IDLE;
            next_state.ax[a].md   = MD_IDLE;
            next_state.ax[a].busy = 1'b0;
            next_state.ax[a].zero = 1'b0;
          end
        end
        PH_IDLE:
        begin
          next_state.ax[a].speed = '0;
        end
      endcase

      // Pulse generation by phase accumulator
      sum = {1'b0, state.ax[a].accu} + {1'b0, state.ax[a].speed};
      next_state.ax[a].accu = sum[SPW-1:0];
      if (sum[SPW])
      begin
        next_state.ax[a].pulse = 1'b1;
        if (state.ax[a].md != MD_SPD)
        begin
          next_state.ax[a].feed = state.ax[a].dir ? state.ax[a].feed - 32'h0000_0001
                                                  : state.ax[a].feed + 32'h0000_0001;
        end
        if (state.ax[a].md == MD_POS)
        begin
          next_state.ax[a].remain = state.ax[a].remain - 32'h0000_0001;
          if (state.ax[a].remain == 32'h0000_0001)
          begin
            next_state.ax[a].ph    = PH_IDLE;
            next_state.ax[a].md    = MD_IDLE;
            next_state.ax[a].busy  = 1'b0;
            next_state.ax[a].done  = 1'b1;
            next_state.ax[a].speed = '0;
          end
        end
      end

      // Dual-axis launch: checked per axis, blocked if any axis busy
      if (launch && !any_busy)
      begin
        dest = state.ax[a].feed + move;
        if (move == '0)
        begin
          next_state.ax[a].done = 1'b1;
        end
        else if ($signed(dest) > $signed(state.cfg[a][R_UPPER]))
        begin
          next_state.ax[a].err = E_SOFT_UP;
        end
        else if ($signed(dest) < $signed(state.cfg[a][R_LOWER]))
        begin
          next_state.ax[a].err = E_SOFT_LO;
        end
        else
        begin
          cl = clamp_spd(state.cfg[a][R_CMD_SPD][SPW-1:0], bias, lim);
          next_state.ax[a].md     = MD_POS;
          next_state.ax[a].busy   = 1'b1;
          next_state.ax[a].done   = 1'b0;
          next_state.ax[a].dir    = move[DW-1];
          next_state.ax[a].remain = move[DW-1] ? -move : move;
          next_state.ax[a].tgt    = cl[SPW-1:0];
          next_state.ax[a].zero   = (cl[SPW-1:0] == '0);
          next_state.ax[a].ph     = PH_ACC;
        end
      end
    end
  end

  // Reset value of the whole block
  localparam ajs_state_t ST_RST = '{ax: {NAX{AX_RST}}, default: '0};

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from state flops
  always_comb
  begin
    prdata  = state.rdata;
    pready  = state.rdy;
    pslverr = state.serr;
    for (int a = 0; a < NAX; a++)
    begin
      pulse_out[a] = state.ax[a].pulse;
      dir_out[a]   = state.ax[a].dir;
    end
  end

endmodule : ajs_axis_ctrl

// file: verif/ajs_axis_chk_sva.sv
/* Checker for the axis jog/speed block, watching its top-level ports.
   Assumes one pclk domain and a protocol-abiding APB master. */
module ajs_axis_chk
  import ajs_pkg::*;
(
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // APB slave
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [DW-1:0]  pwdata,
  input wire logic [DW-1:0]  prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Drive unit
  input wire logic [NAX-1:0] pulse_out,
  input wire logic [NAX-1:0] dir_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Setup cycle, then a completed status read
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_stat;
    pready && !pwrite && paddr[6:2] == R_STATUS;
  endsequence

  property p_ready; s_setup |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_err; pready && paddr[6:2] > 5'h11 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_err_only; pslverr |-> pready && paddr[6:2] > 5'h11; endproperty
  a_err_only: assert property (p_err_only) else $error("stray slave error");
  property p_wo;
    pready && !pwrite && (paddr[6:2] == R_CMD || paddr[6:2] == R_LAUNCH) |-> prdata == '0;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only word read nonzero");
  property p_spd_done; s_stat ##0 prdata[15:8] == OP_SPEED |-> !prdata[S_DONE]; endproperty
  a_spd_done: assert property (p_spd_done) else $error("done in speed mode");
  property p_zero;
    s_stat ##0 prdata[S_ZERO] |->
      prdata[S_BUSY] && (prdata[15:8] == OP_SPEED || prdata[15:8] == OP_JOG);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag state wrong");
  property p_idle; s_stat ##0 !prdata[S_BUSY] |-> prdata[7:4] == 4'h1; endproperty
  a_idle: assert property (p_idle) else $error("not busy yet moving");
  // pready low and no step pulses on the first edge after reset release
  property p_rst; $rose(presetn) |-> !pready && pulse_out == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : ajs_axis_chk

bind ajs_axis_ctrl ajs_axis_chk u_ajs_axis_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_out(pulse_out), .dir_out(dir_out)
);

// file: verif/ajs_drive_model.sv
/* Drive unit model: counts step pulses into a signed position per axis.
   Assumes one high pulse_out cycle is one step; dir_out high is reverse. */
module ajs_drive_model
  import ajs_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Step and direction
  input  wire logic [NAX-1:0]    pulse_out,
  input  wire logic [NAX-1:0]    dir_out,
  // Position per axis
  output logic [NAX-1:0][DW-1:0] pos
);
  timeunit 1ns;
  timeprecision 1ps;
  // Direction latched with each step, as a real drive does
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos <= '0;
    else
      for (int i = 0; i < NAX; i++)
        if (pulse_out[i])
          pos[i] <= dir_out[i] ? pos[i] - 32'h1 : pos[i] + 32'h1;
  end
endmodule : ajs_drive_model

// file: verif/ajs_axis_ctrl_bench.sv
/* Self-checking bench: APB tasks, drive model, seeded random values.
   Assumes the checker binds itself from its own file. */
module ajs_axis_ctrl_bench
  import ajs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [DW-1:0]         pwdata;
  logic [DW-1:0]         prdata;
  logic                  pready;
  logic                  pslverr;
  logic [NAX-1:0]        pulse_out;
  logic [NAX-1:0]        dir_out;
  logic [NAX-1:0][DW-1:0] pos;
  logic [NAX-1:0][DW-1:0] p0;
  logic [NAX-1:0][DW-1:0] mv;
  logic [DW-1:0]         rd;
  logic [DW-1:0]         fv;
  logic                  err;
  logic                  ax;
  int                    mismatches;
  int                    n_tests;
  integer                seed;
  localparam logic [DW-1:0] MSK = 32'h0000_ff05;

  ajs_axis_ctrl u_ajs_axis_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_out(pulse_out), .dir_out(dir_out)
  );
  ajs_drive_model u_ajs_drive_model (
    .pclk(pclk), .presetn(presetn), .pulse_out(pulse_out), .dir_out(dir_out), .pos(pos)
  );

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Expected status word: busy, zero flag, operation state
  function automatic logic [DW-1:0] st(logic b, logic z, logic [7:0] op);
    return {16'h0, op, 5'h0, z, 1'b0, b};
  endfunction : st

  // One APB transfer on axis ax; request held until pready is sampled
  task automatic xfer(input logic w, input logic [IW-1:0] i, input logic [DW-1:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ax, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [IW-1:0] i, input logic [DW-1:0] d);
    xfer(1'b1, i, d);
  endtask : wr

  task automatic rdr(input logic [IW-1:0] i);
    xfer(1'b0, i, '0);
  endtask : rdr

  // Poll status until the masked bits match; a hang ends the run
  task automatic poll(input logic [DW-1:0] m, input logic [DW-1:0] v);
    int n;
    n = 0;
    do
    begin
      rdr(R_STATUS);
      n++;
    end
    while ((rd & m) !== v && n < 4000);
    chk(rd & m, v);
    if ((rd & m) !== v)
      end_sim();
  endtask : poll

  // Wait for standstill, then clear codes
  task automatic settle();
    poll(32'h1, 32'h0);
    wr(R_CMD, 32'h8);
  endtask : settle

  // Main sequence
  initial
  begin
    seed = 32'h3812;
    mismatches = 0;
    n_tests = 0;
    ax = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < NAX; a++)
    begin
      ax = a[0];
      rdr(R_STATUS);
      chk(rd, 32'h10);
      rdr(R_CODES);
      chk(rd, '0);
      // Write-only words must read back as zero
      rdr(R_CMD);
      chk(rd, '0);
      rdr(R_LAUNCH);
      chk(rd, '0);
      wr(R_UPPER, 32'h3e8);
      wr(R_LOWER, 32'hffff_fc18);
    end
    ax = 1'b0;
    wr(R_FEED, 32'h5);
    rdr(R_FEED);
    chk(rd, '0);
    rdr(5'h12);
    chk(32'(err), 32'h1);
    $display("reset test done");
    // Random new values, then the upper bound itself
    for (int k = 0; k < 5; k++)
    begin
      fv = (k == 4) ? 32'h3e8 : $random(seed) % 1000;
      wr(R_NEWVAL, fv);
      wr(R_CMD, 32'h1);
      rdr(R_FEED);
      chk(rd, fv);
    end
    wr(R_NEWVAL, 32'h3e9);
    wr(R_CMD, 32'h1);
    rdr(R_CODES);
    chk(rd, {16'h0, E_SOFT_UP});
    wr(R_CMD, 32'h8);
    wr(R_NEWVAL, 32'hffff_fc17);
    wr(R_CMD, 32'h1);
    rdr(R_CODES);
    chk(rd, {16'h0, E_SOFT_LO});
    rdr(R_FEED);
    chk(rd, fv);
    wr(R_CMD, 32'h8);
    $display("current value test done");
    wr(R_ACC, 32'h28);
    wr(R_DEC, 32'h28);
    wr(R_CTRL, 32'h4);
    wr(R_CMD, 32'h2);
    poll(MSK, st(1'b1, 1'b1, OP_SPEED));
    p0 = pos;
    repeat (40) @(posedge pclk);
    chk(pos[0], p0[0]);
    wr(R_NEWVAL, 32'h1770);
    wr(R_CMD, 32'h4);
    poll(MSK | 32'hf0, st(1'b1, 1'b0, OP_SPEED) | 32'h40);
    rdr(R_FEED);
    chk(rd, '0);
    p0 = pos;
    repeat (100) @(posedge pclk);
    chk(32'($signed(pos[0]) < $signed(p0[0])), 32'h1);
    wr(R_CTRL, 32'h6);
    settle();
    wr(R_CTRL, 32'h0);
    wr(R_BIAS, 32'hbb8);
    wr(R_CMD_SPD, 32'h1388);
    wr(R_CMD, 32'h2);
    wr(R_NEWVAL, 32'h0);
    wr(R_CMD, 32'h4);
    rdr(R_CODES);
    chk(rd, {W_SPD_RANGE, 16'h0});
    p0 = pos;
    repeat (60) @(posedge pclk);
    chk(32'(pos[0] !== p0[0]), 32'h1);
    wr(R_CTRL, 32'h2);
    settle();
    wr(R_CTRL, 32'h0);
    wr(R_BIAS, 32'h0);
    $display("speed test done");
    ax = 1'b1;
    wr(R_JOG_SPD, 32'hbb8);
    wr(R_JOG_ACC, 32'h64);
    wr(R_JOG_DEC, 32'h1e);
    wr(R_CTRL, 32'h1);
    poll(32'hff01, 32'h0201);
    poll(32'hf0, 32'h40);
    wr(R_CTRL, 32'h0);
    rdr(R_STATUS);
    chk(rd & 32'hf1, 32'h81);
    // Speed change to zero mid-ramp-down; an accepted one would raise the zero flag
    wr(R_NEWVAL, 32'h0);
    wr(R_CMD, 32'h4);
    rdr(R_STATUS);
    chk(rd & 32'hf5, 32'h81);
    wr(R_CTRL, 32'h5);
    poll(32'h1, 32'h0);
    repeat (20) @(posedge pclk);
    rdr(R_STATUS);
    chk(rd & 32'h1, 32'h0);
    wr(R_CTRL, 32'h0);
    // Clamp to the limit, then lift to the bias speed
    for (int k = 0; k < 2; k++)
    begin
      wr(R_LIMIT, k ? 32'h0 : 32'h7d0);
      wr(R_BIAS, k ? 32'hfa0 : 32'h0);
      wr(R_CTRL, 32'h1);
      poll(32'hf0, 32'h40);
      rdr(R_CODES);
      chk(rd, {W_SPD_RANGE, 16'h0});
      wr(R_CTRL, 32'h0);
      settle();
    end
    wr(R_BIAS, 32'h0);
    wr(R_CTRL, 32'h1);
    poll(32'hf0, 32'h40);
    wr(R_CTRL, 32'h3);
    rdr(R_STATUS);
    chk(rd & 32'hf0, 32'h80);
    poll(32'h1, 32'h0);
    wr(R_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    rdr(R_STATUS);
    chk(rd & 32'h1, 32'h0);
    wr(R_CTRL, 32'h0);
    wr(R_CTRL, 32'h2);
    wr(R_CTRL, 32'h3);
    rdr(R_CODES);
    chk(rd, {16'h0, E_HALT_AT_START});
    rdr(R_STATUS);
    chk(rd & 32'h1, 32'h0);
    wr(R_CTRL, 32'h2);
    wr(R_CMD, 32'h8);
    wr(R_CTRL, 32'h0);
    wr(R_CTRL, 32'h1);
    poll(32'h1, 32'h1);
    wr(R_CTRL, 32'h0);
    settle();
    wr(R_JOG_SPD, 32'h0);
    wr(R_CTRL, 32'h1);
    poll(MSK, st(1'b1, 1'b1, OP_JOG));
    wr(R_NEWVAL, 32'hbb8);
    wr(R_CMD, 32'h4);
    poll(MSK, st(1'b1, 1'b0, OP_JOG));
    wr(R_CTRL, 32'h0);
    settle();
    $display("jog test done");
    for (int a = 0; a < NAX; a++)
    begin
      ax = a[0];
      mv[a] = 32'ha + ($random(seed) & 32'h1f);
      wr(R_NEWVAL, 32'h0);
      wr(R_CMD, 32'h1);
      wr(R_CMD_SPD, 32'h1f40);
      wr(R_ACC, 32'h32);
      wr(R_MOVE, mv[a]);
    end
    p0 = pos;
    wr(R_LAUNCH, 32'h1);
    for (int a = 0; a < NAX; a++)
    begin
      ax = a[0];
      rdr(R_STATUS);
      chk(rd & 32'hff01, st(1'b1, 1'b0, OP_POS));
    end
    for (int a = 0; a < NAX; a++)
    begin
      ax = a[0];
      poll(32'h3, 32'h2);
      chk(pos[a] - p0[a], mv[a]);
    end
    wr(R_MOVE, 32'h7d0);
    p0 = pos;
    wr(R_LAUNCH, 32'h1);
    rdr(R_CODES);
    chk(rd, {16'h0, E_SOFT_UP});
    wr(R_CMD, 32'h8);
    ax = 1'b0;
    poll(32'h3, 32'h2);
    chk(pos[0] - p0[0], mv[0]);
    chk(pos[1], p0[1]);
    ax = 1'b1;
    wr(R_MOVE, 32'h14);
    ax = 1'b0;
    wr(R_CTRL, 32'h1);
    poll(32'h1, 32'h1);
    p0 = pos;
    wr(R_LAUNCH, 32'h1);
    repeat (200) @(posedge pclk);
    chk(pos[1], p0[1]);
    rdr(R_STATUS);
    chk(rd & 32'hff01, 32'h0201);
    wr(R_CTRL, 32'h0);
    settle();
    $display("launch test done");
    end_sim();
  end
endmodule : ajs_axis_ctrl_bench
